// [bench/tx_input_character_steering_tb_top.sv]
// Self-checking bench for the transmit input steering block.
// Assumes the queue model as far side; pins change at falling edges.
`timescale 1ns/1ps
`include "tx_steer_regs.vh"

module tx_input_character_steering_tb_top;
  reg sys_clk = 1'b0;
  reg arst_n = 1'b0;
  reg [11:0] tx_parallel_word = 12'h000;
  reg halt_now_n = 1'b1, send_violation = 1'b0, cell_start_flag = 1'b0;
  reg special_or_data_sel = 1'b0, queue_bypass_n = 1'b0, coder_bypass_n = 1'b0;
  reg narrow_width_sel = 1'b0, tx_write_en = 1'b0, tx_queue_clock = 1'b0, ref_clock = 1'b0;
  wire queue_has_data, queue_write, queue_read, tx_halted, char_valid;
  wire [11:0] queue_head_word, queue_write_word, char_word;
  wire [2:0] queue_head_ctl, queue_write_ctl, char_cmd;
  integer mismatches = 0, samples_checked = 0, i, k;
  reg got_v, got_w;
  reg [2:0] got_cmd;
  reg [11:0] got_word;

  tx_input_character_steering i_dut (.sys_clk, .arst_n, .tx_parallel_word, .halt_now_n,
    .send_violation, .cell_start_flag, .special_or_data_sel, .queue_bypass_n, .coder_bypass_n,
    .narrow_width_sel, .tx_write_en, .tx_queue_clock, .ref_clock, .queue_has_data,
    .queue_head_word, .queue_head_ctl, .queue_write, .queue_write_word, .queue_write_ctl,
    .queue_read, .tx_halted, .char_valid, .char_cmd, .char_word);
  tx_queue_model i_queue (.sys_clk, .arst_n, .queue_write, .queue_write_word, .queue_write_ctl,
    .queue_read, .queue_has_data, .queue_head_word, .queue_head_ctl);

  // Clock of 4 ns period.
  initial forever #2 sys_clk = ~sys_clk;

  task chk(input [11:0] seen, input [11:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // Pulses one pin clock, 3 cycles high, and records any answer within 8 cycles.
  task edge_pin(input sel);
    begin
      got_v = 1'b0;
      got_w = 1'b0;
      @(negedge sys_clk);
      if (sel) tx_queue_clock = 1'b1; else ref_clock = 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
        @(negedge sys_clk);
        if (i == 2) begin
          tx_queue_clock = 1'b0;
          ref_clock = 1'b0;
        end
        if (char_valid) begin
          got_v = 1'b1;
          got_cmd = char_cmd;
          got_word = char_word;
        end
        if (queue_write) got_w = 1'b1;
      end
    end
  endtask

  task slot(input [2:0] cmd, input [11:0] word);
    begin
      edge_pin(1'b0);
      chk({11'h000, got_v}, 12'h001);
      chk({9'h000, got_cmd}, {9'h000, cmd});
      chk(got_word, word);
    end
  endtask

  // Mode pins change, then four cycles let the synchronisers settle.
  task set_mode(input qb, input cb, input nw);
    begin
      queue_bypass_n = qb;
      coder_bypass_n = cb;
      narrow_width_sel = nw;
      repeat (4) @(negedge sys_clk);
    end
  endtask

  function [2:0] exp_cmd(input [2:0] c);
    exp_cmd = c[2] ? `CMD_VIOL : c[1] ? (c[0] ? `CMD_CELL_SPECIAL : `CMD_CELL_DATA)
      : (c[0] ? `CMD_SPECIAL : `CMD_DATA);
  endfunction

  task finish_test;
    begin
      $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // Main sequence: bypass raw, bypass coded, queued coded with halt, queued raw.
  initial begin
    repeat (4) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    tx_write_en = 1'b1;
    special_or_data_sel = 1'b1;
    tx_parallel_word = 12'hD5A;
    slot(`CMD_RAW, 12'hD5A);
    set_mode(1'b0, 1'b0, 1'b1);
    slot(`CMD_RAW, 12'h15A);
    set_mode(1'b0, 1'b1, 1'b0);
    special_or_data_sel = 1'b0;
    halt_now_n = 1'b0;
    cell_start_flag = 1'b1;
    tx_parallel_word = 12'h3C7;
    slot(`CMD_DATA, 12'h0C7);
    special_or_data_sel = 1'b1;
    slot(`CMD_SPECIAL, 12'h0C7);
    send_violation = 1'b1;
    slot(`CMD_VIOL, 12'h000);
    tx_write_en = 1'b0;
    slot(`CMD_IDLE, 12'h000);
    tx_write_en = 1'b1;
    edge_pin(1'b1);
    chk({11'h000, got_w}, 12'h000);
    set_mode(1'b1, 1'b1, 1'b0);
    for (k = 0; k < 5; k = k + 1) begin
      {send_violation, cell_start_flag, special_or_data_sel} = k[2:0];
      tx_parallel_word = 12'hFA0 + k[11:0];
      edge_pin(1'b1);
      chk({11'h000, got_w}, 12'h001);
      chk({9'h000, queue_write_ctl}, k[11:0]);
      chk(queue_write_word, 12'h0A0 + k[11:0]);
      chk({11'h000, tx_halted}, 12'h001);
    end
    slot(`CMD_IDLE, 12'h000);
    halt_now_n = 1'b1;
    tx_write_en = 1'b0;
    edge_pin(1'b1);
    chk({11'h000, tx_halted}, 12'h000);
    for (k = 0; k < 5; k = k + 1)
      slot(exp_cmd(k[2:0]), (k == 4) ? 12'h000 : 12'h0A0 + k[11:0]);
    set_mode(1'b1, 1'b0, 1'b0);
    halt_now_n = 1'b0;
    tx_write_en = 1'b1;
    tx_parallel_word = 12'hE6B;
    edge_pin(1'b1);
    chk({11'h000, tx_halted}, 12'h000);
    tx_write_en = 1'b0;
    slot(`CMD_RAW, 12'hE6B);
    finish_test;
  end
endmodule // tx_input_character_steering_tb_top

// [bench/tx_queue_model.sv]
// Behavioural transmit queue standing outside the steering block.
// Assumes at most fifteen entries outstanding; no overflow guard.
`timescale 1ns/1ps

module tx_queue_model (
  input wire sys_clk,
  input wire arst_n,
  input wire queue_write,
  input wire [11:0] queue_write_word,
  input wire [2:0] queue_write_ctl,
  input wire queue_read,
  output wire queue_has_data,
  output wire [11:0] queue_head_word,
  output wire [2:0] queue_head_ctl
);
  reg [14:0] mem_ff [0:15];
  reg [3:0] wr_ptr_ff;
  reg [3:0] rd_ptr_ff;
  wire empty = (wr_ptr_ff == rd_ptr_ff);

  // An empty queue shows the inverse of its last entry, so stale data never looks valid.
  assign queue_has_data = !empty;
  assign {queue_head_ctl, queue_head_word} = empty ? ~mem_ff[rd_ptr_ff - 4'h1] : mem_ff[rd_ptr_ff];

  // Writes are taken on every strobe, halted or not; reads pop the head.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_ff <= 4'h0;
      rd_ptr_ff <= 4'h0;
    end else begin
      if (queue_write) begin
        mem_ff[wr_ptr_ff] <= {queue_write_ctl, queue_write_word};
        wr_ptr_ff <= wr_ptr_ff + 4'h1;
      end
      if (queue_read) rd_ptr_ff <= rd_ptr_ff + 4'h1;
    end
  end
endmodule // tx_queue_model

// [bench/tx_steer_sva.sv]
// Concurrent checks on the transmit input steering block's ports.
// Assumes one sys_clk domain and pins held for the synchroniser delay.
`timescale 1ns/1ps
`include "tx_steer_regs.vh"

module tx_steer_sva (
  input wire sys_clk,
  input wire arst_n,
  input wire queue_bypass_n,
  input wire coder_bypass_n,
  input wire narrow_width_sel,
  input wire queue_has_data,
  input wire queue_write,
  input wire [11:0] queue_write_word,
  input wire [2:0] queue_write_ctl,
  input wire queue_read,
  input wire tx_halted,
  input wire char_valid,
  input wire [2:0] char_cmd,
  input wire [11:0] char_word
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Six cycles of a steady raw narrow bypass cover the synchroniser lag.
  sequence raw_narrow_held;
    (narrow_width_sel && !queue_bypass_n && !coder_bypass_n)[*6];
  endsequence

  a_valid_one_cycle: assert property (char_valid |=> !char_valid)
    else $error("character strobe longer than one cycle");
  a_read_in_slot: assert property (queue_read |-> char_valid)
    else $error("queue pop outside a character slot");
  a_read_not_halted: assert property (queue_read |-> !$past(tx_halted))
    else $error("queue pop while halted");
  a_read_needs_data: assert property (queue_read |-> $past(queue_has_data))
    else $error("queue pop while queue empty");
  a_idle_no_read: assert property (char_valid && char_cmd == `CMD_IDLE |-> !queue_read)
    else $error("idle sent yet queue popped");
  a_bypass_no_write: assert property ((!queue_bypass_n)[*5] |-> !queue_write)
    else $error("queue written while bypassed");
  a_bypass_no_halt: assert property ((!queue_bypass_n)[*4] |-> !tx_halted)
    else $error("halted while queue bypassed");
  a_narrow_top_zero: assert property (raw_narrow_held ##0 (char_valid &&
    char_cmd == `CMD_RAW) |-> char_word[11:10] == 2'h0)
    else $error("narrow raw character has upper bits set");
  a_viol_word_zero: assert property (char_valid && char_cmd == `CMD_VIOL |->
    char_word == 12'h000)
    else $error("violation character carries data");
  a_raw_ctl_zero: assert property ((!coder_bypass_n)[*5] ##0 queue_write |->
    queue_write_ctl == 3'h0)
    else $error("raw entry carries control code");
  a_coded_word_byte: assert property (coder_bypass_n[*5] ##0 queue_write |->
    queue_write_word[11:8] == 4'h0)
    else $error("coded entry has upper bits set");
endmodule // tx_steer_sva

bind tx_input_character_steering tx_steer_sva i_sva (.sys_clk, .arst_n, .queue_bypass_n,
  .coder_bypass_n, .narrow_width_sel, .queue_has_data, .queue_write, .queue_write_word,
  .queue_write_ctl, .queue_read, .tx_halted, .char_valid, .char_cmd, .char_word);

// [verilog/edge_strobe.v]
// Rising-edge strobe for a synchronised clock pin.
// Assumes the input is already synchronised to sys_clk.
`timescale 1ns/1ps

module edge_strobe (
  input wire sys_clk,
  input wire arst_n,
  input wire level_in,
  output wire rise_pulse
);

  reg prev_ff;

  // Remembers the last level to find a low-to-high step.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= level_in;
    end
  end

  assign rise_pulse = level_in & ~prev_ff;

endmodule // edge_strobe

// [verilog/sync2.v]
// Two flip-flop synchroniser bank for pins from outside the clock domain.
// Assumes each bit is an independent level; multi-bit words need stability.
`timescale 1ns/1ps

module sync2 #(
  parameter WIDTH = 1
) (
  input wire sys_clk,
  input wire arst_n,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_sync
);

  reg [WIDTH-1:0] stage1_ff;
  reg [WIDTH-1:0] stage2_ff;

  // The first stage feeds only the second stage.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_ff <= {WIDTH{1'b0}};
      stage2_ff <= {WIDTH{1'b0}};
    end else begin
      stage1_ff <= pin_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign pin_sync = stage2_ff;

endmodule // sync2

// [verilog/tx_input_character_steering.v]
// Transmit input steering: decides what parallel bits 8 to 11 and the
// character-type line mean in each FIFO, encoder and width setting.
// Assumes a FIFO on sys_clk outside this block that takes the write
// strobe and word, and offers its head entry and a not-empty level.
`timescale 1ns/1ps
`include "tx_steer_regs.vh"

module tx_input_character_steering (
  input wire sys_clk,
  input wire arst_n,
  input wire [11:0] tx_parallel_word,
  input wire halt_now_n,
  input wire send_violation,
  input wire cell_start_flag,
  input wire special_or_data_sel,
  input wire queue_bypass_n,
  input wire coder_bypass_n,
  input wire narrow_width_sel,
  input wire tx_write_en,
  input wire tx_queue_clock,
  input wire ref_clock,
  input wire queue_has_data,
  input wire [11:0] queue_head_word,
  input wire [2:0] queue_head_ctl,
  output wire queue_write,
  output wire [11:0] queue_write_word,
  output wire [2:0] queue_write_ctl,
  output wire queue_read,
  output wire tx_halted,
  output wire char_valid,
  output wire [2:0] char_cmd,
  output wire [11:0] char_word
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------

  // Builds the raw pre-encoded character from the parallel word.
  function [11:0] raw_char;
    input [11:0] word;
    input narrow;
    begin
      raw_char[`BYTE_MSB:0] = word[`BYTE_MSB:0];
      raw_char[`BIT_NINTH] = word[`BIT_NINTH];
      raw_char[`BIT_TENTH] = word[`BIT_TENTH];
      if (narrow) begin
        raw_char[`BIT_TWELFTH:`BIT_ELEVENTH] = 2'h0;
      end else begin
        raw_char[`BIT_ELEVENTH] = word[`BIT_ELEVENTH];
        raw_char[`BIT_TWELFTH] = word[`BIT_TWELFTH];
      end
    end
  endfunction

  // Maps the combined per-character control code onto an encoder command.
  function [2:0] ctl_to_cmd;
    input [2:0] ctl;
    begin
      if (ctl[`CTL_VIOL]) begin
        ctl_to_cmd = `CMD_VIOL;
      end else if (ctl[`CTL_CELL] && ctl[`CTL_SPEC]) begin
        ctl_to_cmd = `CMD_CELL_SPECIAL;
      end else if (ctl[`CTL_CELL]) begin
        ctl_to_cmd = `CMD_CELL_DATA;
      end else if (ctl[`CTL_SPEC]) begin
        ctl_to_cmd = `CMD_SPECIAL;
      end else begin
        ctl_to_cmd = `CMD_DATA;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------

  wire [11:0] word_s;
  wire [9:0] ctl_s;
  wire halt_n_s;
  wire viol_s;
  wire cell_s;
  wire spec_s;
  wire qbyp_n_s;
  wire cbyp_n_s;
  wire narrow_s;
  wire wr_en_s;
  wire qclk_s;
  wire rclk_s;
  wire qclk_rise;
  wire rclk_rise;

  // Every pin except the FIFO head and not-empty inputs passes two flip-flops before any steering logic reads it.
  sync2 #(
    .WIDTH(12)
  ) u_word_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_in(tx_parallel_word),
    .pin_sync(word_s)
  );

  sync2 #(
    .WIDTH(10)
  ) u_ctl_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_in({halt_now_n, send_violation, cell_start_flag, special_or_data_sel,
             queue_bypass_n, coder_bypass_n, narrow_width_sel, tx_write_en,
             tx_queue_clock, ref_clock}),
    .pin_sync(ctl_s)
  );

  assign halt_n_s = ctl_s[9];
  assign viol_s = ctl_s[8];
  assign cell_s = ctl_s[7];
  assign spec_s = ctl_s[6];
  assign qbyp_n_s = ctl_s[5];
  assign cbyp_n_s = ctl_s[4];
  assign narrow_s = ctl_s[3];
  assign wr_en_s = ctl_s[2];
  assign qclk_s = ctl_s[1];
  assign rclk_s = ctl_s[0];

  // Edge strobes stand in for the two pin clocks.
  edge_strobe u_qclk_edge (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .level_in(qclk_s),
    .rise_pulse(qclk_rise)
  );

  edge_strobe u_rclk_edge (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .level_in(rclk_s),
    .rise_pulse(rclk_rise)
  );

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------

  wire queue_on;
  wire coder_on;
  wire queue_coded;
  wire direct_coded;
  wire direct_raw;

  assign queue_on = qbyp_n_s;
  assign coder_on = cbyp_n_s;
  assign queue_coded = queue_on & coder_on;
  assign direct_coded = ~queue_on & coder_on;
  assign direct_raw = ~queue_on & ~coder_on;

  // ------------------------------------------------------------
  // Write side and halt level, sampled on queue clock edges
  // ------------------------------------------------------------

  reg queue_write_ff;
  reg [11:0] queue_write_word_ff;
  reg [2:0] queue_write_ctl_ff;
  reg halted_ff;
  reg nxt_queue_write;
  reg [11:0] nxt_queue_write_word;
  reg [2:0] nxt_queue_write_ctl;
  reg nxt_halted;

  // Builds the next FIFO entry; halt never blocks this path.
  always @* begin
    nxt_queue_write = 1'b0;
    nxt_queue_write_word = queue_write_word_ff;
    nxt_queue_write_ctl = queue_write_ctl_ff;
    nxt_halted = halted_ff;
    if (!queue_on) begin
      nxt_halted = 1'b0;
    end else if (qclk_rise) begin
      nxt_halted = coder_on & ~halt_n_s;
      if (wr_en_s) begin
        nxt_queue_write = 1'b1;
        if (coder_on) begin
          nxt_queue_write_word = {4'h0, word_s[`BYTE_MSB:0]};
          nxt_queue_write_ctl = {viol_s, cell_s, spec_s};
        end else begin
          nxt_queue_write_word = raw_char(word_s, narrow_s);
          nxt_queue_write_ctl = `RST_CTL;
        end
      end
    end
  end

  // Registers the write side.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      queue_write_ff <= 1'b0;
      queue_write_word_ff <= `RST_WORD;
      queue_write_ctl_ff <= `RST_CTL;
      halted_ff <= 1'b0;
    end else begin
      queue_write_ff <= nxt_queue_write;
      queue_write_word_ff <= nxt_queue_write_word;
      queue_write_ctl_ff <= nxt_queue_write_ctl;
      halted_ff <= nxt_halted;
    end
  end

  // ------------------------------------------------------------
  // Character slot, one per reference clock edge
  // ------------------------------------------------------------

  reg queue_read_ff;
  reg char_valid_ff;
  reg [2:0] char_cmd_ff;
  reg [11:0] char_word_ff;
  reg nxt_queue_read;
  reg nxt_char_valid;
  reg [2:0] nxt_char_cmd;
  reg [11:0] nxt_char_word;

  // Chooses what the encoder gets in each character slot.
  always @* begin
    nxt_queue_read = 1'b0;
    nxt_char_valid = 1'b0;
    nxt_char_cmd = char_cmd_ff;
    nxt_char_word = char_word_ff;
    if (rclk_rise) begin
      nxt_char_valid = 1'b1;
      nxt_char_cmd = `CMD_IDLE;
      nxt_char_word = `RST_WORD;
      if (queue_on) begin
        if (queue_has_data && !halted_ff) begin
          nxt_queue_read = 1'b1;
          nxt_char_word = queue_head_word;
          if (coder_on) begin
            nxt_char_cmd = ctl_to_cmd(queue_head_ctl);
            // A queued violation symbol carries no data byte.
            if (queue_head_ctl[`CTL_VIOL]) begin
              nxt_char_word = `RST_WORD;
            end
          end else begin
            nxt_char_cmd = `CMD_RAW;
          end
        end
      end else if (wr_en_s) begin
        if (direct_raw) begin
          nxt_char_cmd = `CMD_RAW;
          nxt_char_word = raw_char(word_s, narrow_s);
        end else if (direct_coded && viol_s) begin
          nxt_char_cmd = `CMD_VIOL;
        end else begin
          // Cell start and halt play no part here.
          nxt_char_cmd = spec_s ? `CMD_SPECIAL : `CMD_DATA;
          nxt_char_word = {4'h0, word_s[`BYTE_MSB:0]};
        end
      end
    end
  end

  // Registers the character slot.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      queue_read_ff <= 1'b0;
      char_valid_ff <= 1'b0;
      char_cmd_ff <= `RST_CMD;
      char_word_ff <= `RST_WORD;
    end else begin
      queue_read_ff <= nxt_queue_read;
      char_valid_ff <= nxt_char_valid;
      char_cmd_ff <= nxt_char_cmd;
      char_word_ff <= nxt_char_word;
    end
  end

  // ------------------------------------------------------------
  // Outputs, each straight from a flip-flop
  // ------------------------------------------------------------

  assign queue_write = queue_write_ff;
  assign queue_write_word = queue_write_word_ff;
  assign queue_write_ctl = queue_write_ctl_ff;
  assign queue_read = queue_read_ff;
  assign tx_halted = halted_ff;
  assign char_valid = char_valid_ff;
  assign char_cmd = char_cmd_ff;
  assign char_word = char_word_ff;

endmodule // tx_input_character_steering

// [verilog/tx_steer_regs.vh]
// Constants for the transmit input character steering block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef TX_STEER_REGS_VH
`define TX_STEER_REGS_VH

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define WORD_W 12
`define CMD_W 3
`define CTL_W 3

// ------------------------------------------------------------
// Field positions on the parallel word
// ------------------------------------------------------------
`define BYTE_MSB 7
`define BIT_NINTH 8
`define BIT_TENTH 9
`define BIT_ELEVENTH 10
`define BIT_TWELFTH 11
`define NARROW_MSB 9

// Positions inside the queued control code.
`define CTL_VIOL 2
`define CTL_CELL 1
`define CTL_SPEC 0

// ------------------------------------------------------------
// Encoder commands
// ------------------------------------------------------------
`define CMD_DATA 3'h0
`define CMD_SPECIAL 3'h1
`define CMD_IDLE 3'h2
`define CMD_VIOL 3'h3
`define CMD_RAW 3'h4
`define CMD_CELL_DATA 3'h5
`define CMD_CELL_SPECIAL 3'h6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_WORD 12'h000
`define RST_CTL 3'h0
`define RST_CMD 3'h2

`endif
